//--- src/bibc_block_control.sv
// bibc_block_control: activation of two-word i/o instructions into the
// register file and the per-word buffer cycles that follow.
// assumes main control, memory and the eight channels run on sys_clk, so
// their strobes arrive with no synchroniser; fetch2Latch precedes
// fetch2Done by at least one cycle.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: reactivating an active buffer yields reject path
// R2: busy when selected channel or search/move busy
// R3: busy skips delay line and file writes
// R4: busy withholds skip so reject executes
// R5: storage transfers buffered, accumulator ones unbuffered; code marks accumulator ones active and buffers them too
// R6: program loads address extension into accumulator
// R7: program request granted returns resynchronised reply
// R8: second fetch end starts chain, stores words
// R9: interrupts ignored during second fetch
// R10: typewriter addresses preloaded in file
// R11: program request sets flag, halts scanner
// R12: latch channel from databus, send enable
// R13: not busy: skip, then read/write, clear
// R14: channel raises request per direction
// R15: words to 0X and 1X, then release
// R16: instruction register held during second fetch
// R17: buffer cycle steps current address, requests storage
// R18: compare with last address, end after word
// R19: memory reply connects bus for one word
// R20: accumulator input: read-only cycle, upper bits clear
// R21: accumulator output drives the data bus
// R22: program and groups alternate, low channels first
// R23: one granted request serviced at a time
module bibc_block_control
    import bibc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic progReq,
    input wire logic progSelSm,
    input wire logic smBusy,
    input wire logic fetch2Latch,
    input wire logic fetch2Done,
    input wire logic [bibc_pkg::WORD_W-1:0] dbWord,
    input wire logic [bibc_pkg::WORD_W-1:0] firstWord,
    input wire logic [bibc_pkg::WORD_W-1:0] accum,
    input wire logic [bibc_pkg::NCHAN-1:0] chanReq,
    input wire logic [bibc_pkg::WORD_W-1:0] chanDataIn,
    input wire logic memReply,
    input wire logic [bibc_pkg::BUS_AW-1:0] regAddr,
    input wire logic [bibc_pkg::FILE_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [bibc_pkg::FILE_W-1:0] regRdata,
    output bibc_pkg::bibc_main_t mainCtl,
    output logic busy,
    output logic intrInhibit,
    output logic irHold,
    output logic scanHalt,
    output bibc_pkg::bibc_chan_t chanCtl,
    output bibc_pkg::bibc_mem_t memCtl,
    output logic accLoad,
    output logic [bibc_pkg::WORD_W-1:0] accData,
    output logic [bibc_pkg::WORD_W-1:0] busData,
    output logic [bibc_pkg::NCHAN-1:0] blockDone
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        bibc_phase_t phase;
        logic [FILE_DEPTH-1:0][FILE_W-1:0] file;
        logic [1:0] ctrl;
        logic [NCHAN-1:0] chanActive;
        logic [NCHAN-1:0] cmpHit;
        logic [2:0] chan;
        logic chanValid;
        logic isSm;
        logic progTurn;
        logic grpTurn;
        logic [WORD_W-1:0] dbHold;
        logic [WORD_W-1:0] fHold;
        logic [FLD_EXT_W-1:0] extHold;
        logic [2:0] modOp;
        logic [FILE_W-1:0] rdData;
        bibc_main_t main;
        bibc_chan_t ch;
        bibc_mem_t mem;
        logic accLoad;
        logic [WORD_W-1:0] accData;
        logic [WORD_W-1:0] busData;
        logic [NCHAN-1:0] done;
    } bibc_state_t;

    bibc_state_t q;
    bibc_state_t d;

    logic [NCHAN-1:0] chanWant;
    logic grpAny;
    logic busyNow;
    logic [2:0] grantCh;
    logic [5:0] opCode;
    logic [2:0] newModOp;
    logic isWord;
    logic isOutput;
    logic withA;
    logic [5:0] curIdx;
    logic [5:0] lastIdx;
    logic [ADDR_W-1:0] curAddr;
    logic [ADDR_W-1:0] step;

    // lowest set bit of a group of four wins, so channels 0 and 4 lead
    function automatic logic [1:0] lowestOf(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        if (v[0]) begin
            r = 2'h0;
        end else if (v[1]) begin
            r = 2'h1;
        end else if (v[2]) begin
            r = 2'h2;
        end else begin
            r = 2'h3;
        end
        return r;
    endfunction

    // -------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------
    assign chanWant = chanReq & q.chanActive;
    assign grpAny = |chanWant;
    assign opCode = firstWord[FLD_OP_LSB +: 6];
    assign newModOp = {firstWord[FLD_WITH_A_BIT], opCode[1:0]};
    // modified op: 11 and 00 are input, 01 and 10 output; low bit clear is word
    assign withA = q.modOp[2];
    assign isOutput = q.modOp[1] ^ q.modOp[0];
    assign isWord = ~q.modOp[0];
    assign curIdx = {FILE_CUR_BANK, q.chan};
    assign lastIdx = {FILE_LAST_BANK, q.chan};
    assign curAddr = q.file[curIdx][FLD_ADDR_LSB +: ADDR_W];

    always_comb begin
        if (q.ctrl[CTRL_HALF_BIT]) begin
            step = STEP_HALF;
        end else if (isWord) begin
            step = STEP_WORD;
        end else begin
            step = STEP_CHAR;
        end
    end

    always_comb begin
        // group scanner alternates groups; the served group restarts at its top
        if ((q.grpTurn == 1'b0 && |chanWant[3:0]) || ~|chanWant[7:4]) begin
            grantCh = {1'b0, lowestOf(chanWant[3:0])};
        end else begin
            grantCh = {1'b1, lowestOf(chanWant[7:4])};
        end
    end

    // busy is judged against the buffer the request selects
    assign busyNow = q.isSm ? smBusy : q.chanActive[q.chan]; // [R1] [R2]

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        d = q;
        d.main.resyncReply = 1'b0;
        d.main.skipSet = 1'b0;
        d.main.freeBus = 1'b0;
        d.ch.readSig = 1'b0;
        d.ch.writeSig = 1'b0;
        d.ch.clearOut = 1'b0;
        d.ch.connect = 1'b0;
        d.accLoad = 1'b0;
        d.done = '0;

        // register port: file words (interregister transfer), control, status
        if (regWr) begin
            if (regAddr <= OFS_FILE_LAST) begin
                d.file[regAddr[5:0]] = regWdata;
            end else if (regAddr == OFS_CTRL) begin
                d.ctrl = regWdata[1:0];
            end
        end
        if (regRd) begin
            if (regAddr <= OFS_FILE_LAST) begin
                d.rdData = q.file[regAddr[5:0]];
            end else if (regAddr == OFS_CTRL) begin
                d.rdData = {25'h0, q.ctrl};
            end else if (regAddr == OFS_STATUS) begin
                d.rdData = {7'h0, q.phase != PH_IDLE, 1'b0, q.cmpHit, q.chanActive, 2'h0};
            end else begin
                d.rdData = '0;
            end
        end

        case (q.phase)
            PH_IDLE: begin
                // scanners run only here, so one request is serviced at a time [R23]
                if (progReq && (q.progTurn || !grpAny)) begin
                    d.main.progReqFf = 1'b1; // [R11]
                    d.main.resyncReply = 1'b1; // [R7]
                    d.progTurn = 1'b0; // [R22]
                    d.isSm = progSelSm;
                    d.chanValid = 1'b0;
                    d.phase = PH_FETCH2;
                end else if (grpAny) begin
                    d.chan = grantCh;
                    d.grpTurn = ~grantCh[2]; // [R22]
                    d.progTurn = 1'b1;
                    d.phase = PH_BUF0;
                end
            end
            PH_FETCH2: begin
                if (fetch2Latch) begin
                    d.chan = dbWord[FLD_CHAN_LSB +: 3]; // [R12]
                    d.chanValid = ~q.isSm;
                    d.ch.enable = q.isSm ? '0 : 8'h01 << dbWord[FLD_CHAN_LSB +: 3]; // [R12]
                end
                if (fetch2Done) begin
                    d.dbHold = dbWord;
                    d.fHold = firstWord;
                    d.extHold = accum[FLD_EXT_W-1:0];
                    d.modOp = newModOp;
                    if (busyNow) begin
                        // no skip: main control fetches the reject word [R3] [R4]
                        d.main.freeBus = 1'b1;
                        d.main.progReqFf = 1'b0;
                        d.ch.enable = '0;
                        d.phase = PH_IDLE;
                    end else if (q.isSm) begin
                        // search/move runs in its own control once accepted
                        d.main.skipSet = 1'b1;
                        d.main.freeBus = 1'b1;
                        d.main.progReqFf = 1'b0;
                        d.phase = PH_IDLE;
                    end else begin
                        d.main.skipSet = 1'b1; // [R13]
                        d.phase = PH_STORE0; // [R8]
                    end
                end
            end
            PH_STORE0: begin
                // second word plus the accumulator address extension [R15] [R8]
                d.file[curIdx] = {q.modOp, 4'h0, q.extHold, q.dbHold[FLD_ADDR_LOW_W-1:0]};
                d.phase = PH_STORE1;
            end
            PH_STORE1: begin
                d.file[lastIdx] = {3'h0, q.modOp, 1'b0, q.extHold,
                                   q.fHold[FLD_ADDR_LOW_W-1:0]}; // [R15] [R8]
                d.cmpHit[q.chan] = 1'b0;
                d.phase = PH_SIGNAL;
            end
            PH_SIGNAL: begin
                d.ch.readSig = ~isOutput; // [R13]
                d.ch.writeSig = isOutput;
                d.phase = PH_CLEARO;
            end
            PH_CLEARO: begin
                d.ch.clearOut = 1'b1; // [R13]
                d.chanActive[q.chan] = 1'b1; // [R5]
                d.main.freeBus = 1'b1; // [R15]
                d.main.progReqFf = 1'b0;
                d.ch.enable = '0;
                d.phase = PH_IDLE;
            end
            PH_BUF0: begin
                d.modOp = q.file[curIdx][FLD_MODOP_0X_LSB +: 3];
                d.mem.addr = curAddr; // [R17]
                d.phase = PH_BUF1;
            end
            PH_BUF1: begin
                // step size follows the op now held in modOp unless the ctrl half bit is set; direction follows the ctrl down bit
                if (q.ctrl[CTRL_DOWN_BIT]) begin
                    d.file[curIdx][FLD_ADDR_LSB +: ADDR_W] = curAddr - step; // [R17]
                end else begin
                    d.file[curIdx][FLD_ADDR_LSB +: ADDR_W] = curAddr + step; // [R17]
                end
                if (q.file[lastIdx][FLD_ADDR_LSB +: ADDR_W] == q.mem.addr) begin
                    d.cmpHit[q.chan] = 1'b1; // [R18]
                end
                d.mem.storageReq = 1'b1; // [R17] [R19]
                d.mem.readOnly = withA & ~isOutput; // [R20]
                d.phase = PH_MEMWAIT;
            end
            PH_MEMWAIT: begin
                if (memReply) begin
                    d.mem.storageReq = 1'b0;
                    d.phase = PH_XFER; // [R19]
                end
            end
            PH_XFER: begin
                d.ch.connect = 1'b1; // [R19]
                d.ch.sel = q.chan;
                if (withA && !isOutput) begin
                    d.accLoad = 1'b1; // [R20]
                    d.accData = isWord ? chanDataIn : {18'h0, chanDataIn[CHAR_W-1:0]};
                end
                if (withA && isOutput) begin
                    d.busData = accum; // [R21]
                end else begin
                    d.busData = chanDataIn;
                end
                d.mem.readOnly = 1'b0;
                // the word in progress is finished before the block ends [R18]
                if (q.cmpHit[q.chan]) begin
                    d.chanActive[q.chan] = 1'b0;
                    d.done[q.chan] = 1'b1;
                end
                d.phase = PH_IDLE;
            end
            default: begin
                d.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.phase <= PH_IDLE;
        end else if (ce) begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign regRdata = q.rdData;
    assign mainCtl = q.main;
    assign chanCtl = q.ch;
    assign memCtl = q.mem;
    assign accLoad = q.accLoad;
    assign accData = q.accData;
    assign busData = q.busData;
    assign blockDone = q.done;
    assign busy = (q.phase == PH_FETCH2) && busyNow && (q.chanValid || q.isSm); // [R2]
    assign intrInhibit = (q.phase == PH_FETCH2); // [R9]
    assign irHold = (q.phase == PH_FETCH2); // [R16]
    assign scanHalt = q.main.progReqFf; // [R11]

endmodule

`default_nettype wire

//--- src/bibc_pkg.sv
// bibc_pkg: constants, carrier structs and state types for the buffered
// i/o block control.
// assumes one 50 MHz clock shared with main control and the channels.
package bibc_pkg;

    // -------------------------------------------------------------------
    // widths and register file layout
    // -------------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int FILE_W = 27;
    localparam int FILE_DEPTH = 64;
    localparam int ADDR_W = 20;
    localparam int NCHAN = 8;
    localparam int BUS_AW = 7;

    // entry 0X holds the current address, 1X the last address
    localparam logic [2:0] FILE_CUR_BANK = 3'h0;
    localparam logic [2:0] FILE_LAST_BANK = 3'h1;
    localparam int FLD_MODOP_0X_LSB = 24;
    localparam int FLD_MODOP_1X_LSB = 21;
    localparam int FLD_ADDR_LSB = 0;
    localparam int FLD_ADDR_LOW_W = 17;
    localparam int FLD_EXT_W = 3;

    // first word: op code and the with-accumulator designator
    localparam int FLD_OP_LSB = 18;
    localparam int FLD_WITH_A_BIT = 17;
    // second word: channel number in the upper three bits
    localparam int FLD_CHAN_LSB = 21;
    localparam int CHAR_W = 6;

    // -------------------------------------------------------------------
    // register port map
    // -------------------------------------------------------------------
    localparam logic [6:0] OFS_FILE_LAST = 7'h3f;
    localparam logic [6:0] OFS_CTRL = 7'h40;
    localparam logic [6:0] OFS_STATUS = 7'h41;
    localparam int CTRL_HALF_BIT = 0;
    localparam int CTRL_DOWN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam logic [ADDR_W-1:0] STEP_CHAR = 20'h00001;
    localparam logic [ADDR_W-1:0] STEP_HALF = 20'h00002;
    localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00004;

    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic resyncReply;
        logic skipSet;
        logic freeBus;
        logic progReqFf;
    } bibc_main_t;

    typedef struct packed {
        logic [NCHAN-1:0] enable;
        logic readSig;
        logic writeSig;
        logic clearOut;
        logic connect;
        logic [2:0] sel;
    } bibc_chan_t;

    typedef struct packed {
        logic storageReq;
        logic readOnly;
        logic [ADDR_W-1:0] addr;
    } bibc_mem_t;

    typedef enum logic [3:0] {
        PH_IDLE, PH_FETCH2, PH_STORE0, PH_STORE1, PH_SIGNAL, PH_CLEARO,
        PH_BUF0, PH_BUF1, PH_MEMWAIT, PH_XFER
    } bibc_phase_t;

endpackage

//--- testbench/bibc_block_control_sva.sv
// bibc_block_control_sva: timing checks on the block control's outputs.
// assumes a single sys_clk domain and synchronous active-low nrst.
`timescale 1ns/100ps
`default_nettype none
module bibc_block_control_sva
    import bibc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic fetch2Done,
    input wire logic memReply,
    input wire logic busy,
    input wire logic intrInhibit,
    input wire logic irHold,
    input wire logic scanHalt,
    input wire bibc_pkg::bibc_main_t mainCtl,
    input wire bibc_pkg::bibc_chan_t chanCtl,
    input wire bibc_pkg::bibc_mem_t memCtl,
    input wire logic [bibc_pkg::NCHAN-1:0] blockDone
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----
    // activation
    // ----
    property p_busy_refused;
        fetch2Done && busy |=> (!mainCtl.skipSet && !chanCtl.readSig && !chanCtl.writeSig) [*3];
    endproperty
    a_busy_refused: assert property (p_busy_refused)
        else $error("skip or channel signal after busy activation");
    property p_skip_free;
        fetch2Done && !busy |-> ##[1:2] mainCtl.skipSet;
    endproperty
    a_skip_free: assert property (p_skip_free)
        else $error("no skip after free activation");
    property p_rw_follows;
        mainCtl.skipSet && |chanCtl.enable |-> ##[1:4] (chanCtl.readSig || chanCtl.writeSig);
    endproperty
    a_rw_follows: assert property (p_rw_follows)
        else $error("read or write signal missing after skip");
    property p_clear_release;
        chanCtl.readSig || chanCtl.writeSig |=> chanCtl.clearOut && mainCtl.freeBus;
    endproperty
    a_clear_release: assert property (p_clear_release)
        else $error("clear and release do not follow read or write");
    property p_enable_onehot;
        |chanCtl.enable |-> $onehot(chanCtl.enable);
    endproperty
    a_enable_onehot: assert property (p_enable_onehot)
        else $error("channel enable not one-hot");
    property p_hold_fetch;
        mainCtl.resyncReply |=> intrInhibit && irHold && scanHalt;
    endproperty
    a_hold_fetch: assert property (p_hold_fetch)
        else $error("inhibit, hold or halt missing in second fetch");
    property p_inhibit_ends;
        fetch2Done |=> !intrInhibit;
    endproperty
    a_inhibit_ends: assert property (p_inhibit_ends)
        else $error("interrupt inhibit outlasts second fetch");
    property p_busy_phase;
        busy |-> intrInhibit;
    endproperty
    a_busy_phase: assert property (p_busy_phase)
        else $error("busy outside second fetch");
    // ----
    // buffer cycles
    // ----
    property p_store_hold;
        memCtl.storageReq && !memReply |=> memCtl.storageReq;
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("storage request dropped before reply");
    property p_connect;
        memCtl.storageReq && memReply |-> ##2 chanCtl.connect;
    endproperty
    a_connect: assert property (p_connect)
        else $error("no connect two cycles after reply");
    property p_done_pulse;
        |blockDone |=> blockDone == '0;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("block done longer than one cycle");
endmodule
bind bibc_block_control bibc_block_control_sva u_sva (
    .sys_clk(sys_clk), .nrst(nrst), .fetch2Done(fetch2Done), .memReply(memReply),
    .busy(busy), .intrInhibit(intrInhibit), .irHold(irHold), .scanHalt(scanHalt),
    .mainCtl(mainCtl), .chanCtl(chanCtl), .memCtl(memCtl), .blockDone(blockDone)
);
`default_nettype wire

//--- testbench/bibc_partner.sv
// bibc_partner: eight channels and memory facing the block control.
// assumes go gates every channel request; memory alternates fast and slow.
`timescale 1ns/100ps
`default_nettype none
module bibc_partner
    import bibc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic go,
    input wire bibc_pkg::bibc_chan_t chanCtl,
    input wire bibc_pkg::bibc_mem_t memCtl,
    input wire logic [bibc_pkg::NCHAN-1:0] blockDone,
    output logic [bibc_pkg::NCHAN-1:0] chanReq,
    output logic [bibc_pkg::WORD_W-1:0] chanDataIn,
    output logic memReply
);
    localparam logic [WORD_W-1:0] DIN = 24'h5a5a6c;
    logic [NCHAN-1:0] armed, isRd;
    logic [1:0] wt [NCHAN];
    logic [1:0] mCnt;
    logic slow;
    always_comb begin
        for (int i = 0; i < NCHAN; i++) chanReq[i] = go && armed[i] && wt[i] == 2'h0;
    end
    // output register is only valid while a request stands
    assign chanDataIn = |chanReq ? DIN : ~DIN;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            armed <= '0;
            isRd <= '0;
            wt <= '{default: 2'h0};
            mCnt <= 2'h0;
            slow <= 1'b0;
            memReply <= 1'b0;
        end else begin
            for (int i = 0; i < NCHAN; i++) begin
                if (wt[i] != 2'h0) wt[i] <= wt[i] - 2'h1;
                // read waits for the peripheral, write asks at once
                if (chanCtl.enable[i] && (chanCtl.readSig || chanCtl.writeSig)) begin
                    armed[i] <= 1'b1;
                    isRd[i] <= chanCtl.readSig;
                    wt[i] <= chanCtl.readSig ? 2'h3 : 2'h0;
                end
                if (chanCtl.connect && chanCtl.sel == 3'(i)) wt[i] <= isRd[i] ? 2'h3 : 2'h1;
                if (blockDone[i]) armed[i] <= 1'b0;
            end
            memReply <= 1'b0;
            if (memCtl.storageReq && !memReply) begin
                if (mCnt == (slow ? 2'h3 : 2'h0)) begin
                    memReply <= 1'b1;
                    mCnt <= 2'h0;
                    slow <= !slow;
                end else begin
                    mCnt <= mCnt + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// tb_top: self-checking bench for the buffered i/o block control.
// assumes bibc_partner stands in for channels and memory.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bibc_pkg::*;
    typedef struct packed {logic [5:0] op; logic wa; logic [2:0] ch, ac; logic rd;} bibc_row_t;
    logic sys_clk = 0, nrst = 0, ce = 1, progReq = 0, progSelSm = 0, smBusy = 0;
    logic fetch2Latch = 0, fetch2Done = 0, regWr = 0, regRd = 0, go = 0, memReply, busy;
    logic [WORD_W-1:0] dbWord = '0, firstWord = '0, accum = '0, chanDataIn, accData, busData;
    logic [NCHAN-1:0] chanReq, blockDone, doneM = '0;
    logic [BUS_AW-1:0] regAddr = '0;
    logic [FILE_W-1:0] regWdata = '0, regRdata, rv;
    logic intrInhibit, irHold, scanHalt, accLoad, busyHit, srPrev = 0;
    bibc_main_t mainCtl;
    bibc_chan_t chanCtl;
    bibc_mem_t memCtl;
    int n_mismatch = 0, checks_done = 0, nSkip, nRd, nWr, n;
    int nConn [NCHAN] = '{default: 0};
    int expN [NCHAN], stp [NCHAN];
    logic [ADDR_W-1:0] expA [NCHAN];
    always #10 sys_clk = ~sys_clk;
    bibc_block_control dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .progReq(progReq),
        .progSelSm(progSelSm), .smBusy(smBusy), .fetch2Latch(fetch2Latch),
        .fetch2Done(fetch2Done), .dbWord(dbWord), .firstWord(firstWord), .accum(accum),
        .chanReq(chanReq), .chanDataIn(chanDataIn), .memReply(memReply), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .mainCtl(mainCtl), .busy(busy), .intrInhibit(intrInhibit), .irHold(irHold),
        .scanHalt(scanHalt), .chanCtl(chanCtl), .memCtl(memCtl), .accLoad(accLoad),
        .accData(accData), .busData(busData), .blockDone(blockDone));
    bibc_partner u_partner (.sys_clk(sys_clk), .nrst(nrst), .go(go), .chanCtl(chanCtl),
        .memCtl(memCtl), .blockDone(blockDone), .chanReq(chanReq), .chanDataIn(chanDataIn),
        .memReply(memReply));
    // ----
    // helpers
    // ----
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wr(input logic [6:0] a, input logic [26:0] d);
        @(posedge sys_clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 0;
    endtask
    task rd(input logic [6:0] a);
        @(posedge sys_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 0;
        @(posedge sys_clk);
        rv = regRdata;
    endtask
    task act(input logic [23:0] fw, db, ac, input logic sm, sb);
        @(posedge sys_clk);
        progReq <= 1;
        progSelSm <= sm;
        smBusy <= sb;
        firstWord <= fw;
        dbWord <= db;
        accum <= ac;
        {nSkip, nRd, nWr, n} = '0;
        busyHit = 0;
        do @(posedge sys_clk); while (mainCtl.resyncReply !== 1'b1 && ++n < 20);
        progReq <= 0;
        fetch2Latch <= 1;
        @(posedge sys_clk);
        fetch2Latch <= 0;
        fetch2Done <= 1;
        @(posedge sys_clk);
        fetch2Done <= 0;
        do @(posedge sys_clk); while (mainCtl.freeBus !== 1'b1 && ++n < 40);
        @(posedge sys_clk);
        chk("activation end", n < 40, 1);
    endtask
    // sees the values that stood during the cycle before each edge
    always @(posedge sys_clk) begin
        if (mainCtl.skipSet) nSkip++;
        if (chanCtl.readSig) nRd++;
        if (chanCtl.writeSig) nWr++;
        if (fetch2Done && busy) busyHit = 1;
        doneM = nrst ? doneM | blockDone : '0;
        // sel moves only at connect; block base is 0x100 + 16 * channel
        if (memCtl.storageReq && !srPrev) begin
            chk("buffer addr", memCtl.addr, expA[memCtl.addr[6:4]]);
            if (memCtl.addr[6:4] == 3'd7) chk("read only", memCtl.readOnly, 1);
            expA[memCtl.addr[6:4]] = expA[memCtl.addr[6:4]] + ADDR_W'(stp[memCtl.addr[6:4]]);
        end
        srPrev = memCtl.storageReq;
        if (chanCtl.connect) nConn[chanCtl.sel]++;
        if (chanCtl.connect && chanCtl.sel == 3'd5) chk("bus data", busData, accum);
        if (accLoad) chk("acc data", accData, {18'h0, 6'h2c});
    end
    initial begin
        #(20 * 20000);
        n_mismatch++;
        wrap_up;
    end
    // ----
    // main sequence
    // ----
    initial begin
        bibc_row_t rows [4];
        bibc_row_t r;
        logic [16:0] a, fa;
        logic [2:0] m;
        rows = '{'{6'h3c, 1'b0, 3'd0, 3'd1, 1'b1}, '{6'h3d, 1'b0, 3'd3, 3'd5, 1'b0},
                 '{6'h3e, 1'b1, 3'd5, 3'd6, 1'b0}, '{6'h3b, 1'b1, 3'd7, 3'd2, 1'b1}};
        repeat (10) @(posedge sys_clk);
        nrst <= 1;
        rd(OFS_CTRL);
        chk("ctrl reset", rv, CTRL_RESET);
        rd(OFS_STATUS);
        chk("status reset", rv, 0);
        wr(7'h1b, 27'h0000140);
        rd(7'h1b);
        chk("type end", rv, 27'h0000140);
        foreach (rows[i]) begin
            r = rows[i];
            m = {r.wa, r.op[1:0]};
            stp[r.ch] = r.op[0] ? 1 : 4;
            expN[r.ch] = r.wa ? 1 : 3;
            a = 17'h00100 + 17'({r.ch, 4'h0});
            fa = r.wa ? a : a + 17'(2 * stp[r.ch]);
            expA[r.ch] = {r.ac, a};
            act({r.op, r.wa, fa}, {r.ch, 4'h0, a}, {21'h0, r.ac}, 0, 0);
            chk("skip", nSkip, 1);
            chk("read sig", nRd, r.rd);
            chk("write sig", nWr, !r.rd);
            rd(7'(r.ch));
            chk("entry 0X", rv, {m, 4'h0, r.ac, a});
            rd(7'(8 + r.ch));
            chk("entry 1X", rv, {3'h0, m, 1'b0, r.ac, fa});
        end
        rd(OFS_STATUS);
        chk("active set", rv[9:2], 8'ha9);
        act({6'h3c, 1'b0, 17'h0}, {3'd0, 4'h0, 17'h1ff}, 24'h0, 0, 0);
        chk("busy seen", busyHit, 1);
        chk("no skip", nSkip, 0);
        chk("no rw", nRd + nWr, 0);
        rd(7'h00);
        chk("0X kept", rv, 27'h0020100);
        act(24'h0, {3'd1, 21'h0}, 24'h0, 1, 1);
        chk("sm busy", busyHit, 1);
        chk("sm busy skip", nSkip, 0);
        act(24'h0, {3'd1, 21'h0}, 24'h0, 1, 0);
        chk("sm free skip", nSkip, 1);
        rd(7'h55);
        chk("unmapped", rv, 0);
        accum <= 24'h123456;
        go <= 1;
        n = 0;
        do @(posedge sys_clk); while (doneM !== 8'ha9 && ++n < 3000);
        chk("blocks done", doneM, 8'ha9);
        repeat (4) @(posedge sys_clk);
        foreach (rows[i]) begin
            r = rows[i];
            chk("words moved", nConn[r.ch], expN[r.ch]);
            rd(7'(r.ch));
            chk("stepped addr", rv[19:0], expA[r.ch]);
        end
        rd(OFS_STATUS);
        chk("active clear", rv[9:2], 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
